/* hdl/apgo_top.sv */
// power, invert, gain and offset register bank with its AHB-Lite slave
// Operation
// - reg 18h bits 15..12 power down digital block of converters 4..1.
// - reg 18h bits 11..8 shut down serial output lines 4..1.
// - reg 18h bits 7..4 power down analog block of converters 4..1.
// - reg 18h bits 3..0 invert sample data on serial lines 4..1.
// - test patterns pass through unaffected by inversion bits.
// - every bit of reg 18h resets to zero.
// - correction bits 15..11 give gain code N, gain N times 0.2 dB.
// - gain applied only while global gain enable, reg 3 bit 12, is set.
// - bits 9..0 signed offset in 14-bit LSBs, subtracted from sample.
// - offset subtracted only while global offset enable, reg 3 bit 8, is set.
// - 19h corrects converter 5 odd, 1Ah converter 5 even, 1Bh converter 6 odd.
`timescale 1ns/1ps
`default_nettype none
module apgo_top
    import apgo_pkg::*;
#(
    parameter int LINES = 4,
    parameter int STREAMS = 3,
    parameter int SW = 14
) (
    input wire logic clock,
    input wire logic rstn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic [31:0] hrdata,
    output logic hresp,
    input wire logic [LINES-1:0][SW-1:0] line_sample,
    input wire logic [LINES-1:0] line_sample_valid,
    input wire logic [LINES-1:0] pattern_on,
    input wire logic [LINES-1:0][SW-1:0] pattern_word,
    output logic [LINES-1:0][SW-1:0] line_data,
    output logic [LINES-1:0] line_data_valid,
    output logic [3:0] conv_digital_sleep,
    output logic [3:0] conv_analog_sleep,
    output logic [3:0] serial_line_sleep,
    output logic [3:0] serial_line_data_flip,
    output logic global_gain_correct_on,
    output logic global_offset_correct_on,
    input wire logic [STREAMS-1:0][SW-1:0] corr_sample,
    input wire logic [STREAMS-1:0] corr_sample_valid,
    output logic [STREAMS-1:0][SW-1:0] corr_out,
    output logic [STREAMS-1:0] corr_out_valid
);
    // ************************************************************
    // state
    // ************************************************************
    typedef struct packed {
        apgo_bus_t bus;
        logic [7:0] idx;
        logic [31:0] rd;
        logic [15:0] glob;
        logic [15:0] pwr;
        logic [2:0][15:0] corr;
    } apgo_regs_t;

    apgo_regs_t r;
    apgo_regs_t next_r;
    logic take;
    logic [7:0] addr_idx;

    // register read mux, unmapped reads as zero
    function automatic logic [15:0] read_word(input apgo_regs_t s);
        logic [15:0] w;
        w = 16'h0000;
        unique case (s.idx)
            IDX_GLOBAL: w = s.glob;
            IDX_PWR: w = s.pwr;
            IDX_C5_ODD: w = s.corr[0];
            IDX_C5_EVEN: w = s.corr[1];
            IDX_C6_ODD: w = s.corr[2];
            default: w = 16'h0000;
        endcase
        return w;
    endfunction : read_word

    // ************************************************************
    // AHB-Lite slave
    // ************************************************************
    // address phase decode, only aligned word accesses map
    assign take = hsel && hready && htrans[1];
    always_comb begin
        addr_idx = IDX_NONE;
        if (haddr[31:10] == 22'h000000 && haddr[1:0] == 2'h0 && hsize == HSIZE_WORD) begin
            addr_idx = haddr[9:2];
        end
    end

    // data phase work and next address phase
    always_comb begin
        next_r = r;
        unique case (r.bus)
            BUS_IDLE: begin
            end
            BUS_WRITE: begin
                unique case (r.idx)
                    IDX_GLOBAL: next_r.glob = hwdata[15:0] & GLOBAL_MASK;
                    IDX_PWR: next_r.pwr = hwdata[15:0];
                    IDX_C5_ODD: next_r.corr[0] = hwdata[15:0] & CORR_MASK;
                    IDX_C5_EVEN: next_r.corr[1] = hwdata[15:0] & CORR_MASK;
                    IDX_C6_ODD: next_r.corr[2] = hwdata[15:0] & CORR_MASK;
                    default: begin
                    end
                endcase
            end
            BUS_RDWAIT: begin
                next_r.rd = {16'h0000, read_word(r)};
            end
            BUS_RDDONE: begin
            end
        endcase
        if (r.bus == BUS_RDWAIT) begin
            next_r.bus = BUS_RDDONE;
        end else if (take) begin
            next_r.bus = hwrite ? BUS_WRITE : BUS_RDWAIT;
            next_r.idx = addr_idx;
        end else begin
            next_r.bus = BUS_IDLE;
        end
    end

    // register words and read data reset to zero, bus state to idle and index to none
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            r.bus <= BUS_IDLE;
            r.idx <= IDX_NONE;
            r.rd <= 32'h00000000;
            r.glob <= REG_RST;
            r.pwr <= REG_RST;
            r.corr <= {3{REG_RST}};
        end else begin
            r <= next_r;
        end
    end

    // bus answers, one wait state on reads
    assign hreadyout = (r.bus != BUS_RDWAIT);
    assign hrdata = r.rd;
    assign hresp = 1'b0;

    // ************************************************************
    // control outputs
    // ************************************************************
    assign conv_digital_sleep = r.pwr[DIG_SLEEP_LO+:4];
    assign serial_line_sleep = r.pwr[LINE_SLEEP_LO+:4];
    assign conv_analog_sleep = r.pwr[ANA_SLEEP_LO+:4];
    assign serial_line_data_flip = r.pwr[FLIP_LO+:4];
    assign global_gain_correct_on = r.glob[GAIN_EN_BIT];
    assign global_offset_correct_on = r.glob[OFFS_EN_BIT];

    // ************************************************************
    // serial lines and correction streams
    // ************************************************************
    // line g carries converter g data
    for (genvar g = 0; g < LINES; g++) begin : g_line
        apgo_line #(.SW(SW)) u_line (
            .clock(clock),
            .rstn(rstn),
            .sample(line_sample[g]),
            .sample_valid(line_sample_valid[g]),
            .pattern_on(pattern_on[g]),
            .pattern_word(pattern_word[g]),
            .flip(serial_line_data_flip[g]),
            .line_sleep(serial_line_sleep[g]),
            .conv_sleep(conv_digital_sleep[g]),
            .data(line_data[g]),
            .data_valid(line_data_valid[g])
        );
    end

    // stream 0 conv5 odd, 1 conv5 even, 2 conv6 odd
    for (genvar g = 0; g < STREAMS; g++) begin : g_corr
        apgo_correct u_corr (
            .clock(clock),
            .rstn(rstn),
            .gain_code(r.corr[g][15:GAIN_LO]),
            .offset_code(r.corr[g][9:0]),
            .gain_on(global_gain_correct_on),
            .offset_on(global_offset_correct_on),
            .sample(corr_sample[g]),
            .sample_valid(corr_sample_valid[g]),
            .out(corr_out[g]),
            .out_valid(corr_out_valid[g])
        );
    end

    // ************************************************************
    // checks
    // ************************************************************
    logic pwr_touched;
    logic wr_pwr;
    assign wr_pwr = (r.bus == BUS_WRITE) && (r.idx == IDX_PWR);

    // remembers whether software has written the power register yet
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            pwr_touched <= 1'b0;
        end else if (wr_pwr) begin
            pwr_touched <= 1'b1;
        end
    end

    a_dig_sleep_wr: assert property (@(posedge clock) disable iff (!rstn)
        wr_pwr |=> conv_digital_sleep == $past(hwdata[15:12]))
        else $error("digital sleep bits not taken from write");
    a_line_sleep_out: assert property (@(posedge clock) disable iff (!rstn)
        wr_pwr && hwdata[8] |=> ##1 !line_data_valid[0] && line_data[0] == 14'h0000)
        else $error("sleeping line still sends");
    a_ana_sleep_wr: assert property (@(posedge clock) disable iff (!rstn)
        wr_pwr |=> conv_analog_sleep == $past(hwdata[7:4]))
        else $error("analog sleep bits not taken from write");
    a_flip_path: assert property (@(posedge clock) disable iff (!rstn)
        line_sample_valid[1] && !pattern_on[1] && serial_line_data_flip[1]
        && !serial_line_sleep[1] && !conv_digital_sleep[1]
        |=> line_data_valid[1] && line_data[1] == ~$past(line_sample[1]))
        else $error("line two data not inverted");
    a_pattern_pass: assert property (@(posedge clock) disable iff (!rstn)
        pattern_on[2] && !serial_line_sleep[2]
        |=> line_data_valid[2] && line_data[2] == $past(pattern_word[2]))
        else $error("test pattern altered");
    a_reset_zero: assert property (@(posedge clock) disable iff (!rstn)
        !pwr_touched |-> conv_digital_sleep == 4'h0 && serial_line_sleep == 4'h0
        && conv_analog_sleep == 4'h0 && serial_line_data_flip == 4'h0)
        else $error("power register not zero after reset");
    a_offset_sub: assert property (@(posedge clock) disable iff (!rstn)
        corr_sample_valid[0] && global_offset_correct_on && !global_gain_correct_on
        && corr_sample[0][13] == corr_sample[0][12]
        |-> ##2 corr_out[0] == 14'($past(corr_sample[0], 2)
        - {{4{$past(r.corr[0][9], 2)}}, $past(r.corr[0][9:0], 2)}))
        else $error("offset not subtracted");
    a_offset_gate: assert property (@(posedge clock) disable iff (!rstn)
        corr_sample_valid[2] && !global_offset_correct_on && !global_gain_correct_on
        |-> ##2 corr_out[2] == $past(corr_sample[2], 2))
        else $error("offset applied while disabled");
    a_stream_map: assert property (@(posedge clock) disable iff (!rstn)
        corr_sample_valid[1] && global_offset_correct_on && !global_gain_correct_on
        && corr_sample[1][13] == corr_sample[1][12]
        |-> ##2 corr_out[1] == 14'($past(corr_sample[1], 2)
        - {{4{$past(r.corr[1][9], 2)}}, $past(r.corr[1][9:0], 2)}))
        else $error("even stream not corrected by its register");
    a_zero_bit: assert property (@(posedge clock) disable iff (!rstn)
        r.bus == BUS_WRITE && (r.idx == IDX_C5_ODD || r.idx == IDX_C6_ODD)
        |=> r.corr[0][ZERO_BIT] == 1'b0 && r.corr[2][ZERO_BIT] == 1'b0)
        else $error("bit ten stored as one");
    a_read_wait: assert property (@(posedge clock) disable iff (!rstn)
        take && !hwrite |=> !hreadyout ##1 hreadyout)
        else $error("read answer not after one wait state");

    c_write_pwr: cover property (@(posedge clock) disable iff (!rstn) wr_pwr);
    c_read_back: cover property (@(posedge clock) disable iff (!rstn)
        r.bus == BUS_RDDONE && hrdata != 32'h00000000);
    c_pattern: cover property (@(posedge clock) disable iff (!rstn)
        pattern_on[0] && serial_line_data_flip[0]);
    c_both_corr: cover property (@(posedge clock) disable iff (!rstn)
        global_gain_correct_on && global_offset_correct_on && corr_out_valid[0]);
endmodule : apgo_top
`default_nettype wire

/* inc/apgo_pkg.sv */
// shared constants and types of the power, invert, gain and offset register bank
package apgo_pkg;
    // ************************************************************
    // register indices (byte address is four times the index)
    // ************************************************************
    localparam logic [7:0] IDX_GLOBAL = 8'h03;
    localparam logic [7:0] IDX_PWR = 8'h18;
    localparam logic [7:0] IDX_C5_ODD = 8'h19;
    localparam logic [7:0] IDX_C5_EVEN = 8'h1A;
    localparam logic [7:0] IDX_C6_ODD = 8'h1B;
    localparam logic [7:0] IDX_NONE = 8'hFF;

    // ************************************************************
    // field positions and reset values
    // ************************************************************
    localparam int GAIN_EN_BIT = 12;
    localparam int OFFS_EN_BIT = 8;
    localparam int DIG_SLEEP_LO = 12;
    localparam int LINE_SLEEP_LO = 8;
    localparam int ANA_SLEEP_LO = 4;
    localparam int FLIP_LO = 0;
    localparam int GAIN_LO = 11;
    localparam int ZERO_BIT = 10;
    localparam logic [15:0] REG_RST = 16'h0000;
    localparam logic [15:0] GLOBAL_MASK = 16'h1100;
    localparam logic [15:0] CORR_MASK = 16'hFBFF;
    localparam logic [2:0] HSIZE_WORD = 3'h2;

    // ************************************************************
    // gain factors, 10^(N*0.2/20) with 12 fraction bits
    // ************************************************************
    localparam int GAIN_FRAC = 12;
    localparam logic [13:0] GAIN_UNITY = 14'h1000;
    localparam logic [13:0] GAIN_TBL [32] = '{
        14'h1000, 14'h105F, 14'h10C1, 14'h1125, 14'h118B, 14'h11F4, 14'h125F, 14'h12CD,
        14'h133D, 14'h13B0, 14'h1425, 14'h149D, 14'h1518, 14'h1596, 14'h1617, 14'h169A,
        14'h1721, 14'h17AB, 14'h1838, 14'h18C9, 14'h195C, 14'h19F3, 14'h1A8E, 14'h1B2C,
        14'h1BCE, 14'h1C74, 14'h1D1D, 14'h1DCB, 14'h1E7D, 14'h1F32, 14'h1FED, 14'h20AB};
    localparam logic signed [29:0] SAT_MAX = 30'sh00001FFF;
    localparam logic signed [29:0] SAT_MIN = -30'sh00002000;

    // ************************************************************
    // bus slave states
    // ************************************************************
    typedef enum logic [3:0] {
        BUS_IDLE = 4'h1,
        BUS_WRITE = 4'h2,
        BUS_RDWAIT = 4'h4,
        BUS_RDDONE = 4'h8
    } apgo_bus_t;
endpackage : apgo_pkg

/* hdl/apgo_line.sv */
// one serial output line: sleep, test pattern and data inversion
`timescale 1ns/1ps
`default_nettype none
module apgo_line
    import apgo_pkg::*;
#(
    parameter int SW = 14
) (
    input wire logic clock,
    input wire logic rstn,
    input wire logic [SW-1:0] sample,
    input wire logic sample_valid,
    input wire logic pattern_on,
    input wire logic [SW-1:0] pattern_word,
    input wire logic flip,
    input wire logic line_sleep,
    input wire logic conv_sleep,
    output logic [SW-1:0] data,
    output logic data_valid
);
    typedef struct packed {
        logic v;
        logic [SW-1:0] d;
    } apgo_line_t;

    apgo_line_t r;
    apgo_line_t next_r;

    // pick what the line carries next cycle
    always_comb begin
        next_r = r;
        next_r.v = 1'b0;
        if (line_sleep) begin
            next_r.d = '0;
        end else if (pattern_on) begin
            next_r.v = 1'b1;
            next_r.d = pattern_word;
        end else if (conv_sleep) begin
            next_r.d = '0;
        end else if (sample_valid) begin
            next_r.v = 1'b1;
            next_r.d = flip ? ~sample : sample;
        end
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

    assign data = r.d;
    assign data_valid = r.v;
endmodule : apgo_line
`default_nettype wire

/* hdl/apgo_correct.sv */
// offset subtraction then digital gain for one sample stream
`timescale 1ns/1ps
`default_nettype none
module apgo_correct
    import apgo_pkg::*;
(
    input wire logic clock,
    input wire logic rstn,
    input wire logic [4:0] gain_code,
    input wire logic [9:0] offset_code,
    input wire logic gain_on,
    input wire logic offset_on,
    input wire logic [13:0] sample,
    input wire logic sample_valid,
    output logic [13:0] out,
    output logic out_valid
);
    typedef struct packed {
        logic v1;
        logic signed [14:0] diff;
        logic [13:0] fac;
        logic v2;
        logic [13:0] res;
    } apgo_corr_t;

    apgo_corr_t r;
    apgo_corr_t next_r;
    logic signed [29:0] prod;
    logic signed [29:0] scaled;

    // stage one subtracts the offset, stage two scales and clips
    always_comb begin
        next_r = r;
        next_r.v1 = sample_valid;
        next_r.diff = $signed({sample[13], sample});
        if (offset_on) begin
            next_r.diff = $signed({sample[13], sample})
                - $signed({{5{offset_code[9]}}, offset_code});
        end
        next_r.fac = gain_on ? GAIN_TBL[gain_code] : GAIN_UNITY;
        prod = r.diff * $signed({1'b0, r.fac});
        scaled = prod >>> GAIN_FRAC;
        next_r.v2 = r.v1;
        if (scaled > SAT_MAX) begin
            next_r.res = SAT_MAX[13:0];
        end else if (scaled < SAT_MIN) begin
            next_r.res = SAT_MIN[13:0];
        end else begin
            next_r.res = scaled[13:0];
        end
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

    assign out = r.res;
    assign out_valid = r.v2;

    // ************************************************************
    // checks
    // ************************************************************
    a_gain_step: assert property (@(posedge clock) disable iff (!rstn)
        sample_valid && gain_on && !offset_on && gain_code == 5'h0A
        && sample == 14'h03E8 |-> ##2 out == 14'h04EB)
        else $error("gain code ten not applied");
    a_gain_gate: assert property (@(posedge clock) disable iff (!rstn)
        sample_valid && !gain_on && !offset_on |-> ##2 out == $past(sample, 2))
        else $error("gain applied while disabled");
    a_corr_order: assert property (@(posedge clock) disable iff (!rstn)
        sample_valid && gain_on && offset_on && gain_code == 5'h0A
        && offset_code == 10'h064 && sample == 14'h03E8 |-> ##2 out == 14'h046D)
        else $error("offset not subtracted before gain");
    c_gain_used: cover property (@(posedge clock) disable iff (!rstn)
        sample_valid && gain_on && gain_code != 5'h00);
endmodule : apgo_correct
`default_nettype wire

/* sim/tb_top.sv */
// self-checking bench of the power, invert, gain and offset register bank
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, got) begin compares++; if ((got) !== (ex)) begin err_total++; \
    $display("mismatch %s exp %h got %h", nm, ex, got); end end
module tb_top
    import apgo_pkg::*;
;
    logic clock = 0;
    logic rstn = 0;
    logic hsel = 0;
    logic [31:0] haddr = '0;
    logic [1:0] htrans = '0;
    logic hwrite = 0;
    logic [2:0] hsize = HSIZE_WORD;
    logic [31:0] hwdata = '0;
    logic hreadyout;
    logic hresp;
    logic [31:0] hrdata;
    logic [3:0][13:0] line_sample = '0;
    logic [3:0][13:0] pattern_word = '0;
    logic [3:0][13:0] line_data;
    logic [3:0] line_sample_valid = '0;
    logic [3:0] pattern_on = '0;
    logic [3:0] line_data_valid;
    logic [3:0] dsl;
    logic [3:0] asl;
    logic [3:0] lsl;
    logic [3:0] flp;
    logic gon;
    logic oon;
    logic [2:0][13:0] corr_sample = '0;
    logic [2:0][13:0] corr_out;
    logic [2:0] corr_sample_valid = '0;
    logic [2:0] corr_out_valid;
    int err_total = 0;
    int compares = 0;
    logic [31:0] q_reg[$];
    logic [13:0] q_line[4][$];
    logic [13:0] q_corr[3][$];
    logic [31:0] e32;
    logic [13:0] e14;
    logic rd_ph = 0;
    logic [7:0] idx_list [5] = '{IDX_GLOBAL, IDX_PWR, IDX_C5_ODD, IDX_C5_EVEN, IDX_C6_ODD};

    apgo_top DUT (.clock(clock), .rstn(rstn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .line_sample(line_sample),
        .line_sample_valid(line_sample_valid), .pattern_on(pattern_on),
        .pattern_word(pattern_word), .line_data(line_data), .line_data_valid(line_data_valid),
        .conv_digital_sleep(dsl), .conv_analog_sleep(asl), .serial_line_sleep(lsl),
        .serial_line_data_flip(flp), .global_gain_correct_on(gon),
        .global_offset_correct_on(oon), .corr_sample(corr_sample),
        .corr_sample_valid(corr_sample_valid), .corr_out(corr_out),
        .corr_out_valid(corr_out_valid));

    // ************************************************************
    // clock, bus tasks and reference model
    // ************************************************************
    always #5 clock = ~clock;

    // one single AHB-Lite transfer, waits on hready in both phases
    task automatic bus(input logic wr, input logic [7:0] idx, input logic [31:0] d,
        input logic [2:0] sz = HSIZE_WORD);
        @(posedge clock);
        hsel <= 1;
        htrans <= 2'b10;
        hwrite <= wr;
        haddr <= {22'h0, idx, 2'b00};
        hsize <= sz;
        do @(posedge clock); while (hreadyout !== 1'b1);
        hsel <= 0;
        htrans <= 2'b00;
        hwdata <= d;
        do @(posedge clock); while (hreadyout !== 1'b1);
    endtask : bus

    // read with the expected word noted for the watcher
    task automatic rd(input logic [7:0] idx, input logic [31:0] ex);
        q_reg.push_back(ex);
        bus(0, idx, 32'h0);
    endtask : rd

    // offset first, then gain of n times 0.2 dB, saturated to 14 bits
    function automatic logic [13:0] corr_exp(input logic [13:0] s, input logic [15:0] r,
        input logic g, input logic o);
        longint d;
        longint f;
        d = longint'($signed(s));
        if (o) d = d - longint'($signed(r[9:0]));
        f = g ? longint'($rtoi(4096.0 * (10.0 ** (r[15:11] / 100.0)) + 0.5)) : 4096;
        d = (d * f) >>> 12;
        if (d > 8191) d = 8191;
        if (d < -8192) d = -8192;
        return d[13:0];
    endfunction : corr_exp

    task automatic finish_test;
        $display("compares %0d err_total %0d", compares, err_total);
        if (err_total == 0 && compares > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : finish_test

    // watcher: takes the oldest note whenever a result shows
    always @(posedge clock) begin
        if (rd_ph && hreadyout) begin
            rd_ph = 0;
            `CHK("hresp", 1'b0, hresp)
            if (q_reg.size() == 0) `CHK("read extra", 1'b0, 1'b1)
            else begin
                e32 = q_reg.pop_front();
                `CHK("hrdata", e32, hrdata)
            end
        end
        if (hsel && htrans[1] && hreadyout && !hwrite) rd_ph = 1;
        for (int i = 0; i < 4; i++) begin
            if (line_data_valid[i] && q_line[i].size() == 0) `CHK("line extra", 1'b0, 1'b1)
            else if (line_data_valid[i]) begin
                e14 = q_line[i].pop_front();
                `CHK("line data", e14, line_data[i])
            end
        end
        for (int j = 0; j < 3; j++) begin
            if (corr_out_valid[j] && q_corr[j].size() == 0) `CHK("corr extra", 1'b0, 1'b1)
            else if (corr_out_valid[j]) begin
                e14 = q_corr[j].pop_front();
                `CHK("corr out", e14, corr_out[j])
            end
        end
    end

    // watchdog cuts a hang short
    initial begin
        #200000;
        err_total++;
        finish_test();
    end

    // ************************************************************
    // main sequence
    // ************************************************************
    initial begin
        logic [15:0] v;
        logic [15:0] cr;
        int pend;
        void'($urandom(46));
        repeat (2) @(posedge clock);
        rstn <= 1;
        @(posedge clock);
        #1;
        `CHK("sleep flip", 16'h0, {dsl, lsl, asl, flp})
        `CHK("enables", 2'b00, {gon, oon})
        for (int k = 0; k < 5; k++) rd(idx_list[k], 32'h0);
        // power-down and inversion fields land on their outputs
        for (int k = 0; k < 4; k++) begin
            v = (k == 0) ? 16'hFFFF : 16'($urandom);
            bus(1, IDX_PWR, {16'hFFFF, v});
            #1;
            `CHK("digital sleep", v[15:12], dsl)
            `CHK("line sleep", v[11:8], lsl)
            `CHK("analog sleep", v[7:4], asl)
            `CHK("data flip", v[3:0], flp)
            rd(IDX_PWR, {16'h0, v});
        end
        // refused accesses, fixed-zero bits
        bus(1, IDX_PWR, 32'h5555, 3'h0);
        rd(IDX_PWR, {16'h0, v});
        bus(1, IDX_NONE, 32'hFFFF);
        rd(IDX_NONE, 32'h0);
        bus(1, IDX_GLOBAL, 32'hFFFF);
        rd(IDX_GLOBAL, 32'h1100);
        bus(1, IDX_C6_ODD, 32'hFFFF);
        rd(IDX_C6_ODD, 32'hFBFF);
        // correction streams in every enable mode
        for (int m = 0; m < 4; m++) begin
            bus(1, IDX_GLOBAL, {19'h0, m[1], 3'h0, m[0], 8'h0});
            #1;
            `CHK("global enables", m[1:0], {gon, oon})
            for (int j = 0; j < 3; j++) begin
                // conv5 odd gets gain code ten and offset 100 once gain is on
                cr = (j == 0 && m > 1) ? 16'h5064 : 16'($urandom) & CORR_MASK;
                bus(1, 8'(IDX_C5_ODD + j), {16'h0, cr | 16'h0400});
                @(posedge clock);
                for (int n = 0; n < 4; n++) begin
                    v = (n == 0) ? 16'h2000 : (n == 1) ? 16'h1FFF
                        : (n == 2) ? 16'h03E8 : 16'($urandom);
                    corr_sample[j] <= v[13:0];
                    corr_sample_valid[j] <= 1;
                    q_corr[j].push_back(corr_exp(v[13:0], cr, m[1], m[0]));
                    @(posedge clock);
                end
                corr_sample_valid[j] <= 0;
            end
        end
        // lines: plain, flipped, flipped pattern, line sleep, digital sleep
        for (int i = 0; i < 4; i++) begin
            for (int k = 0; k < 6; k++) begin
                v = 16'($urandom);
                bus(1, IDX_PWR, 32'((int'(k inside {1, 2}) << i) | (int'(k == 3) << (8 + i))
                    | (int'(k > 3) << (12 + i))));
                @(posedge clock);
                line_sample[i] <= v[13:0];
                // pattern differs from both the plain and the flipped sample
                pattern_word[i] <= v[13:0] ^ 14'h1555;
                line_sample_valid[i] <= 1;
                pattern_on[i] <= k inside {2, 3, 5};
                if (k inside {2, 5}) q_line[i].push_back(v[13:0] ^ 14'h1555);
                else if (k < 2) q_line[i].push_back(k == 1 ? ~v[13:0] : v[13:0]);
                @(posedge clock);
                line_sample_valid[i] <= 0;
                pattern_on[i] <= 0;
            end
        end
        repeat (5) @(posedge clock);
        // a second reset in mid-run clears every field again
        rstn <= 0;
        repeat (2) @(posedge clock);
        rstn <= 1;
        @(posedge clock);
        #1;
        `CHK("sleep flip", 16'h0, {dsl, lsl, asl, flp})
        `CHK("enables", 2'b00, {gon, oon})
        rd(IDX_PWR, 32'h0);
        rd(IDX_C6_ODD, 32'h0);
        repeat (3) @(posedge clock);
        pend = q_reg.size() + q_line[0].size() + q_line[1].size() + q_line[2].size()
            + q_line[3].size() + q_corr[0].size() + q_corr[1].size() + q_corr[2].size();
        `CHK("pending", 0, pend)
        finish_test();
    end
endmodule : tb_top
`default_nettype wire
